// ==== rtl/msc_device.sv ====
// Module end: select gating, reset filter and execution, attention output
`default_nettype none

module msc_device #(
  parameter int unsigned INIT_CYC = msc_pkg::T_INIT_CYC,
  parameter int unsigned MIN_PULSE_CYC = msc_pkg::MIN_RESET_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  msc_link_if.device link,
  input wire logic core_sda_drive,
  input wire logic fault_event,
  input wire logic flags_read,
  input wire logic setting_we,
  input wire logic [msc_pkg::SETTING_W-1:0] setting_d,
  output logic core_scl,
  output logic core_sda,
  output logic core_selected,
  output logic [msc_pkg::SETTING_W-1:0] setting,
  output logic data_not_ready,
  output logic low_power_mode,
  output logic module_in_reset
);
  import msc_pkg::*;

  localparam int unsigned IW = $clog2(INIT_CYC + 1);
  localparam int unsigned PW = $clog2(MIN_PULSE_CYC + 1);
  localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYC - 1);
  localparam logic [PW-1:0] PULSE_FULL = PW'(MIN_PULSE_CYC);

  // ==========================================================
  // Pin synchronisers
  logic [DS_W-1:0] sync1_r;
  logic [DS_W-1:0] sync2_r;
  logic [DS_W-1:0] pins;
  logic sel;
  logic rst_pin_low;

  assign pins = {link.low_power_request, link.module_reset_n, link.module_select_n, link.sda, link.scl};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Idle levels of all pins are high except low power
      sync1_r <= 5'h0f;
      sync2_r <= 5'h0f;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  assign sel = ~sync2_r[DS_SEL];
  assign rst_pin_low = ~sync2_r[DS_RST];

  // ==========================================================
  // Bus gating towards the management core
  logic core_scl_r;
  logic core_scl_nxt;
  logic core_sda_r;
  logic core_sda_nxt;
  logic core_sel_r;
  logic core_sel_nxt;
  logic sda_oe_r;
  logic sda_oe_nxt;

  always_comb begin
    // Deselected core sees an idle bus so no transfer can start
    core_sel_nxt = sel;
    core_scl_nxt = sel ? sync2_r[DS_SCL] : 1'b1;
    core_sda_nxt = sel ? sync2_r[DS_SDA] : 1'b1;
    sda_oe_nxt = sel & core_sda_drive;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_sel_r <= 1'b0;
      core_scl_r <= 1'b1;
      core_sda_r <= 1'b1;
      sda_oe_r <= 1'b0;
    end else begin
      core_sel_r <= core_sel_nxt;
      core_scl_r <= core_scl_nxt;
      core_sda_r <= core_sda_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // ==========================================================
  // Reset pulse filter and execution sequence
  msc_dev_state_e state_r;
  msc_dev_state_e state_nxt;
  logic [PW-1:0] low_cnt_r;
  logic [PW-1:0] low_cnt_nxt;
  logic [IW-1:0] init_cnt_r;
  logic [IW-1:0] init_cnt_nxt;
  logic dnr_r;
  logic dnr_nxt;
  logic init_done;
  logic full_reset;

  always_comb begin
    state_nxt = state_r;
    init_cnt_nxt = init_cnt_r;
    dnr_nxt = dnr_r;
    init_done = 1'b0;
    // Pulse shorter than the minimum never reaches the full count
    low_cnt_nxt = rst_pin_low ? ((low_cnt_r == PULSE_FULL) ? low_cnt_r : low_cnt_r + 1'b1) : '0;
    full_reset = rst_pin_low && (low_cnt_r == PULSE_FULL);
    case (state_r)
      DEV_INIT: begin
        if (full_reset) begin
          state_nxt = DEV_HELD;
        end else if (init_cnt_r == INIT_LAST) begin
          state_nxt = DEV_RUN;
          dnr_nxt = 1'b0;
          init_done = 1'b1;
        end else begin
          init_cnt_nxt = init_cnt_r + 1'b1;
        end
      end
      DEV_RUN: begin
        if (full_reset) begin
          state_nxt = DEV_HELD;
          dnr_nxt = 1'b1;
        end
      end
      DEV_HELD: begin
        if (!rst_pin_low) begin
          // Execution interval counts from the release edge
          state_nxt = DEV_INIT;
          init_cnt_nxt = '0;
        end
      end
      default: begin
        state_nxt = DEV_INIT;
        init_cnt_nxt = '0;
        dnr_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Power-up runs the same execution interval
      state_r <= DEV_INIT;
      low_cnt_r <= '0;
      init_cnt_r <= '0;
      dnr_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      low_cnt_r <= low_cnt_nxt;
      init_cnt_r <= init_cnt_nxt;
      dnr_r <= dnr_nxt;
    end
  end

  // ==========================================================
  // User settings
  logic [SETTING_W-1:0] setting_r;
  logic [SETTING_W-1:0] setting_nxt;

  always_comb begin
    setting_nxt = setting_r;
    if (full_reset || state_r == DEV_HELD) begin
      setting_nxt = SETTING_RST;
    end else if (setting_we) begin
      setting_nxt = setting_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      setting_r <= SETTING_RST;
    end else begin
      setting_r <= setting_nxt;
    end
  end

  // ==========================================================
  // Attention, presence and power mode pins
  logic pend_r;
  logic pend_nxt;
  logic attn_oe_r;
  logic lp_r;
  logic prs_oe_r;
  logic in_reset_r;

  always_comb begin
    // A new event in the clearing cycle is kept
    if (state_r == DEV_HELD) begin
      pend_nxt = 1'b0;
    end else begin
      pend_nxt = init_done | fault_event | (pend_r & ~flags_read);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= 1'b0;
      attn_oe_r <= 1'b0;
      lp_r <= 1'b0;
      prs_oe_r <= 1'b1;
      in_reset_r <= 1'b1;
    end else begin
      pend_r <= pend_nxt;
      attn_oe_r <= pend_nxt;
      lp_r <= sync2_r[DS_LP];
      prs_oe_r <= 1'b1;
      in_reset_r <= (state_nxt != DEV_RUN);
    end
  end

  // Open-drain pins only ever pull low
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_oe_r;
  assign link.dev_attn_o = 1'b0;
  assign link.dev_attn_oe = attn_oe_r;
  assign link.dev_prs_o = 1'b0;
  assign link.dev_prs_oe = prs_oe_r;

  assign core_scl = core_scl_r;
  assign core_sda = core_sda_r;
  assign core_selected = core_sel_r;
  assign setting = setting_r;
  assign data_not_ready = dnr_r;
  assign low_power_mode = lp_r;
  assign module_in_reset = in_reset_r;
endmodule : msc_device
`default_nettype wire

// ==== rtl/msc_host.sv ====
// Host board end: select, reset pulse, low power, attention service
`default_nettype none
module msc_host #(
  parameter int unsigned PULSE_CYC = msc_pkg::HOST_RESET_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  msc_link_if.host link,
  input wire logic select_req,
  input wire logic reset_req,
  input wire logic low_power_req,
  input wire logic scl_drive,
  input wire logic sda_drive_low,
  output logic sda_seen,
  output logic attention_seen,
  output logic module_present,
  output logic status_valid,
  output logic service_req
);
  import msc_pkg::*;

  localparam int unsigned CW = $clog2(PULSE_CYC + 1);
  localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYC - 1);

  // ==========================================================
  // Pin synchronisers
  logic [HS_W-1:0] sync1_r;
  logic [HS_W-1:0] sync2_r;
  logic attn_prev_r;
  logic attn_low;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      attn_prev_r <= 1'b0;
    end else begin
      sync1_r <= {link.sda, link.module_present_n, link.attention_n};
      sync2_r <= sync1_r;
      attn_prev_r <= attn_low;
    end
  end

  assign attn_low = ~sync2_r[HS_ATTN];

  // ==========================================================
  // Reset and service sequence
  msc_host_state_e state_r;
  msc_host_state_e state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic svc_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    svc_nxt = 1'b0;
    case (state_r)
      HST_WAIT: begin
        if (reset_req) begin
          state_nxt = HST_PULSE;
          cnt_nxt = '0;
        end else if (attn_low && !attn_prev_r) begin
          // Only a fresh fall ends the wait; a stale low may still sit in the synchroniser
          state_nxt = HST_IDLE;
          svc_nxt = 1'b1;
        end
      end
      HST_IDLE: begin
        if (reset_req) begin
          state_nxt = HST_PULSE;
          cnt_nxt = '0;
        end else if (attn_low && !attn_prev_r) begin
          svc_nxt = 1'b1;
        end
      end
      HST_PULSE: begin
        if (cnt_r == PULSE_LAST) begin
          state_nxt = HST_WAIT;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = HST_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= HST_WAIT;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Registered pin drive and user outputs
  logic sel_oe_r;
  logic rst_o_r;
  logic lp_r;
  logic scl_r;
  logic sda_oe_r;
  logic svc_r;
  logic valid_r;
  logic attn_r;
  logic prs_r;
  logic sda_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_oe_r <= 1'b0;
      rst_o_r <= 1'b1;
      lp_r <= 1'b0;
      scl_r <= 1'b1;
      sda_oe_r <= 1'b0;
      svc_r <= 1'b0;
      valid_r <= 1'b0;
      attn_r <= 1'b0;
      prs_r <= 1'b0;
      sda_r <= 1'b1;
    end else begin
      sel_oe_r <= select_req;
      rst_o_r <= (state_nxt != HST_PULSE);
      lp_r <= low_power_req;
      scl_r <= scl_drive;
      sda_oe_r <= sda_drive_low;
      svc_r <= svc_nxt;
      valid_r <= (state_nxt == HST_IDLE);
      attn_r <= attn_low;
      prs_r <= ~sync2_r[HS_PRS];
      sda_r <= sync2_r[HS_SDA];
    end
  end

  assign link.scl = scl_r;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_oe_r;
  // Idle select is released to the module pull-up
  assign link.host_sel_o = 1'b0;
  assign link.host_sel_oe = sel_oe_r;
  assign link.host_rst_o = rst_o_r;
  assign link.host_rst_oe = 1'b1;
  assign link.low_power_request = lp_r;

  assign sda_seen = sda_r;
  assign attention_seen = attn_r;
  assign module_present = prs_r;
  assign status_valid = valid_r;
  assign service_req = svc_r;
endmodule : msc_host
`default_nettype wire

// ==== rtl/msc_link_if.sv ====
// Sideband pins between host board and pluggable module
`default_nettype none
interface msc_link_if;
  // ==========================================================
  // Drivers
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_sel_o;
  logic host_sel_oe;
  logic host_rst_o;
  logic host_rst_oe;
  logic low_power_request;
  logic dev_attn_o;
  logic dev_attn_oe;
  logic dev_prs_o;
  logic dev_prs_oe;

  // ==========================================================
  // Resolved wires; undriven lines sit at their pull-up
  logic sda;
  logic module_select_n;
  logic module_reset_n;
  logic attention_n;
  logic module_present_n;

  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  assign module_select_n = host_sel_oe ? host_sel_o : 1'b1;
  assign module_reset_n = host_rst_oe ? host_rst_o : 1'b1;
  assign attention_n = dev_attn_oe ? dev_attn_o : 1'b1;
  assign module_present_n = dev_prs_oe ? dev_prs_o : 1'b1;

  modport device (
    input scl, sda, module_select_n, module_reset_n, low_power_request,
    output dev_sda_o, dev_sda_oe, dev_attn_o, dev_attn_oe, dev_prs_o, dev_prs_oe
  );
  modport host (
    input sda, attention_n, module_present_n,
    output scl, host_sda_o, host_sda_oe, host_sel_o, host_sel_oe, host_rst_o, host_rst_oe, low_power_request
  );
endinterface : msc_link_if
`default_nettype wire

// ==== rtl/msc_pkg.sv ====
// Shared constants and types for the module sideband control ends
`default_nettype none
package msc_pkg;
  // ==========================================================
  // Clock
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;

  // ==========================================================
  // Timing, in microseconds, then cycles
  // Least reset pulse the module accepts as a full reset
  localparam int unsigned MIN_RESET_PULSE_US = 10;
  localparam int unsigned MIN_RESET_PULSE_CYC = MIN_RESET_PULSE_US * CLK_MHZ;
  // Reset execution interval after the reset pin rises
  localparam int unsigned T_INIT_US = 2000;
  localparam int unsigned T_INIT_CYC = T_INIT_US * CLK_MHZ;
  // Host drives its reset pulse comfortably above the module minimum
  localparam int unsigned HOST_RESET_PULSE_US = 20;
  localparam int unsigned HOST_RESET_PULSE_CYC = HOST_RESET_PULSE_US * CLK_MHZ;

  // ==========================================================
  // User settings
  localparam int unsigned SETTING_W = 8;
  localparam logic [SETTING_W-1:0] SETTING_RST = 8'h00;

  // ==========================================================
  // Synchroniser bit positions, device side
  localparam int unsigned DS_SCL = 0;
  localparam int unsigned DS_SDA = 1;
  localparam int unsigned DS_SEL = 2;
  localparam int unsigned DS_RST = 3;
  localparam int unsigned DS_LP = 4;
  localparam int unsigned DS_W = 5;

  // Synchroniser bit positions, host side
  localparam int unsigned HS_ATTN = 0;
  localparam int unsigned HS_PRS = 1;
  localparam int unsigned HS_SDA = 2;
  localparam int unsigned HS_W = 3;

  // ==========================================================
  // States
  typedef enum logic [1:0] {DEV_INIT, DEV_RUN, DEV_HELD} msc_dev_state_e;
  typedef enum logic [1:0] {HST_WAIT, HST_IDLE, HST_PULSE} msc_host_state_e;
endpackage : msc_pkg
`default_nettype wire

// ==== verification/module_sideband_control_tb_top.sv ====
// Bench joining host and module ends across the sideband pins
`default_nettype none
module module_sideband_control_tb_top;
  import msc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int id; logic [7:0] exp;} msc_note_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic select_req = 1'b0, reset_req = 1'b0, low_power_req = 1'b0, scl_drive = 1'b1, sda_drive_low = 1'b0;
  logic core_sda_drive = 1'b0, fault_event = 1'b0, flags_read = 1'b0, setting_we = 1'b0;
  logic [SETTING_W-1:0] setting_d = 8'h00;
  logic core_scl, core_sda, core_selected, data_not_ready, low_power_mode, module_in_reset;
  logic [SETTING_W-1:0] setting;
  logic sda_seen, attention_seen, module_present, status_valid, service_req;
  logic [7:0] r = 8'h60;
  logic lvl;
  logic [7:0] svc_count = 8'h00;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  msc_note_s notes[$];
  msc_note_s cur;
  string nm [12] = '{"sda_seen", "attention_seen", "module_present", "status_valid", "data_not_ready",
    "low_power_mode", "core_selected", "core_scl", "core_sda", "module_in_reset", "setting", "service_req"};

  msc_link_if msc_link_if_inst ();
  msc_device #(.INIT_CYC(20), .MIN_PULSE_CYC(4)) msc_device_inst (.clk, .rstn,
    .link(msc_link_if_inst.device), .core_sda_drive, .fault_event, .flags_read, .setting_we,
    .setting_d, .core_scl, .core_sda, .core_selected, .setting, .data_not_ready, .low_power_mode,
    .module_in_reset);
  msc_host #(.PULSE_CYC(8)) msc_host_inst (.clk, .rstn, .link(msc_link_if_inst.host), .select_req,
    .reset_req, .low_power_req, .scl_drive, .sda_drive_low, .sda_seen, .attention_seen,
    .module_present, .status_valid, .service_req);
  msc_link_monitor msc_link_monitor_inst (.clk, .rstn, .host_sel_oe(msc_link_if_inst.host_sel_oe),
    .module_select_n(msc_link_if_inst.module_select_n), .module_reset_n(msc_link_if_inst.module_reset_n),
    .dev_sda_o(msc_link_if_inst.dev_sda_o), .dev_sda_oe(msc_link_if_inst.dev_sda_oe),
    .dev_attn_o(msc_link_if_inst.dev_attn_o), .dev_attn_oe(msc_link_if_inst.dev_attn_oe),
    .attention_n(msc_link_if_inst.attention_n), .module_present_n(msc_link_if_inst.module_present_n));

  initial begin
    forever #20 clk = ~clk;
  end

  // ==========================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic [7:0] obs(input int id);
    case (id)
      0: obs = {7'h00, sda_seen};
      1: obs = {7'h00, attention_seen};
      2: obs = {7'h00, module_present};
      3: obs = {7'h00, status_valid};
      4: obs = {7'h00, data_not_ready};
      5: obs = {7'h00, low_power_mode};
      6: obs = {7'h00, core_selected};
      7: obs = {7'h00, core_scl};
      8: obs = {7'h00, core_sda};
      9: obs = {7'h00, module_in_reset};
      11: obs = svc_count;
      default: obs = setting;
    endcase
  endfunction : obs

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic note(input int id, input logic [7:0] v);
    notes.push_back('{id, v});
  endtask : note

  // Bounded wait; a miss shows up in the note that follows
  task automatic wait_for(input int id, input logic [7:0] v);
    int n;
    n = 0;
    while (obs(id) !== v && n < 80) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_for

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic clear_attention();
    flags_read <= 1'b1;
    @(posedge clk);
    flags_read <= 1'b0;
    cyc(6);
    note(1, 8'h00);
  endtask : clear_attention

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Outputs settle after the rising edge, so compare on the falling one
  always @(negedge clk) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      check(nm[cur.id], obs(cur.id), cur.exp);
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    // Service pulses last one cycle, so they are counted here
    if (service_req === 1'b1) begin
      svc_count <= svc_count + 8'h01;
    end
    if (cycles == 2000) begin
      fail_count++;
      $display("mismatch cycle_limit expected 0 seen 1");
      end_of_test();
    end
  end

  // ==========================================
  // Scenarios
  initial begin
    cyc(16);
    rstn <= 1'b1;
    wait_for(1, 8'h01);
    note(1, 8'h01);
    note(4, 8'h00);
    note(3, 8'h01);
    note(2, 8'h01);
    note(9, 8'h00);
    note(11, 8'h01);
    clear_attention();
    $display("test powerup done");
    for (int i = 0; i < 16; i++) begin
      r = lfsr(r);
      select_req <= r[0];
      scl_drive <= r[1];
      core_sda_drive <= r[2];
      sda_drive_low <= r[3];
      cyc(8);
      lvl = ~(r[3] | (r[0] & r[2]));
      note(6, {7'h00, r[0]});
      note(7, {7'h00, r[0] ? r[1] : 1'b1});
      note(8, {7'h00, r[0] ? lvl : 1'b1});
      note(0, {7'h00, lvl});
    end
    select_req <= 1'b0;
    core_sda_drive <= 1'b0;
    sda_drive_low <= 1'b0;
    $display("test select done");
    fault_event <= 1'b1;
    @(posedge clk);
    fault_event <= 1'b0;
    cyc(6);
    note(1, 8'h01);
    note(11, 8'h02);
    clear_attention();
    low_power_req <= 1'b1;
    cyc(6);
    note(5, 8'h01);
    low_power_req <= 1'b0;
    cyc(6);
    note(5, 8'h00);
    $display("test fault and low power done");
    r = lfsr(r) | 8'h01;
    setting_we <= 1'b1;
    setting_d <= r;
    @(posedge clk);
    setting_we <= 1'b0;
    cyc(2);
    note(10, r);
    reset_req <= 1'b1;
    @(posedge clk);
    reset_req <= 1'b0;
    cyc(3);
    note(3, 8'h00);
    cyc(10);
    note(10, 8'h00);
    note(4, 8'h01);
    note(9, 8'h01);
    wait_for(1, 8'h01);
    note(1, 8'h01);
    note(4, 8'h00);
    note(3, 8'h01);
    note(11, 8'h03);
    clear_attention();
    $display("test reset done");
    @(negedge clk);
    @(negedge clk);
    end_of_test();
  end
endmodule : module_sideband_control_tb_top
`default_nettype wire

// ==== verification/msc_link_monitor.sv ====
// Concurrent checks on the sideband pins between host and module ends
`default_nettype none
module msc_link_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic host_sel_oe,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_attn_o,
  input wire logic dev_attn_oe,
  input wire logic attention_n,
  input wire logic module_present_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================
  // Select gating, sync path plus one register
  AST_DESELECT_QUIET: assert property (module_select_n [*5] |-> !dev_sda_oe)
    else $error("data line pulled while deselected");
  AST_UNDRIVEN_SELECT: assert property (!host_sel_oe [*5] |-> !dev_sda_oe)
    else $error("data line pulled with select undriven");
  AST_SDA_PULL_ONLY: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("data line driven high");
  // ==========================================
  // Reset pin and completion attention
  AST_RESET_CLEARS: assert property (!module_reset_n [*8] |=> attention_n)
    else $error("attention kept through a full reset");
  AST_EXEC_QUIET: assert property ($rose(module_reset_n) |-> attention_n [*8])
    else $error("attention before execution interval ended");
  AST_EXEC_DONE: assert property ($rose(module_reset_n) |-> ##[20:26] !attention_n)
    else $error("no completion attention after reset");
  AST_POWERUP_DONE: assert property ($rose(rstn) |-> attention_n [*8] ##[10:16] !attention_n)
    else $error("no completion attention after power-up");
  AST_HOST_PULSE: assert property ($fell(module_reset_n) |-> !module_reset_n [*8] ##1 module_reset_n)
    else $error("host reset pulse length wrong");
  // ==========================================
  // Open-drain attention and fixed presence
  AST_ATTN_PULL_ONLY: assert property (dev_attn_oe |-> !dev_attn_o)
    else $error("attention driven high");
  AST_PRESENT: assert property (!module_present_n)
    else $error("presence not low while seated");
endmodule : msc_link_monitor
`default_nettype wire
